// ===== tsio_pkg.sv
// Shared constants and types for the timer based serial block
package tsio_pkg;
  localparam int TSIO_DATA_W = 8;              // Bits per character
  localparam int TSIO_TMR_W = 16;              // Base timer and compare width
  localparam int TSIO_GRP_W = 2;               // Width of the timer group number
  localparam logic [1:0] TSIO_SER_GROUPS = 2'h2; // Groups below this carry the serial function
  localparam int TSIO_FIFO_DEPTH = 16;         // Transmit buffer depth in words
  localparam int TSIO_FRAME_W = 10;            // Start, eight data, stop
  localparam logic [3:0] TSIO_ASYNC_LAST = 4'h9; // Index of the stop bit
  localparam logic [3:0] TSIO_SYNC_LAST = 4'h7;  // Index of the last data bit
  localparam logic [3:0] TSIO_RX_STOP = 4'h9;    // Receive sample index of the stop bit
  localparam logic [3:0] TSIO_RX_START = 4'h0;   // Receive sample index of the start bit
  localparam int TSIO_CFG_W = TSIO_TMR_W + 2;  // Enable, mode and compare value
  // Reset values
  localparam logic [TSIO_TMR_W-1:0] TSIO_TMR_RST = 16'h0000;
  localparam logic [TSIO_DATA_W-1:0] TSIO_DATA_RST = 8'h00;
  localparam logic [TSIO_FRAME_W-1:0] TSIO_SHIFT_RST = 10'h3ff;
  localparam logic [3:0] TSIO_IDX_RST = 4'h0;
  localparam logic TSIO_LINE_IDLE = 1'b1;       // Line and transfer clock idle high
  localparam logic TSIO_WAVE_RST = 1'b1;        // Compare output level at rest

  typedef enum logic {TSIO_TX_IDLE, TSIO_TX_SHIFT} tsio_tx_st_t;
  typedef enum logic {TSIO_RX_IDLE, TSIO_RX_RUN} tsio_rx_st_t;
endpackage : tsio_pkg

// ===== tsio_fifo.sv
// Single clock FIFO for transmit buffer words
`timescale 1ns/1ps
module tsio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,                 // Clock
  input wire logic rst_n,               // Async reset, active low
  input wire logic in_valid,            // Writer offers a word
  output logic in_ready,                // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word written
  output logic out_valid,               // Word available
  input wire logic out_ready,           // Reader takes the word
  output logic [WIDTH-1:0] out_data     // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  // Storage has no reset; only pointers define validity
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap on the depth, which is kept a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
      if (push && !pop) cnt_r <= cnt_r + CW'(1);
      else if (pop && !push) cnt_r <= cnt_r - CW'(1);
    end
  end
endmodule : tsio_fifo

// ===== tsio_top.sv
// Timer based serial transmitter in synchronous and UART modes, and UART receiver
// Function
// - Serial modes exist only in timer groups 0,1
// - Sync shift clock from phase-delayed compare channel
// - Buffer write starts synchronous shifting on pin
// - UART bit clock from phase-delayed compare
// - UART frame: start, eight data, stop
// - Transmit request only after stop bit sent (UART) or last data bit sent (sync)
// - Receive edge capture marks frame start
// - Start detection launches receive bit clock
// - Receive request on detected stop bit
// - Compare output inverts on timer match
`timescale 1ns/1ps
module tsio_top
  import tsio_pkg::*;
(
  input wire logic clk,                                 // System clock, 125 MHz
  input wire logic rst_n,                               // Async reset, active low
  input wire logic link_clk,                            // Base timer count clock
  input wire logic serial_en,                           // Serial function enable
  input wire logic [tsio_pkg::TSIO_GRP_W-1:0] group_id, // Timer group hosting the block
  input wire logic mode_async,                          // 1 UART, 0 clock synchronous
  input wire logic [tsio_pkg::TSIO_TMR_W-1:0] half_bit, // Compare value, half bit period minus one, in link clocks
  input wire logic transmit_buffer_wr,                  // Write strobe to transmit buffer
  output logic transmit_buffer_rdy,                     // Transmit buffer has room
  input wire logic [tsio_pkg::TSIO_DATA_W-1:0] transmit_buffer_data, // Word written
  output logic tx_irq,                                  // Transmit done request pulse
  output logic rx_irq,                                  // Receive done request pulse
  output logic rx_err,                                  // Stop bit was low, pulse
  output logic [tsio_pkg::TSIO_DATA_W-1:0] rx_data,     // Last received character
  output logic serial_tx_pin,                           // Serial data out
  output logic serial_clk_pin,                          // Transfer clock out, sync mode
  input wire logic serial_rx_pin                        // Serial data in
);
  import tsio_pkg::*;

  // ---------------- System clock domain ----------------
  logic fifo_valid;
  logic [TSIO_DATA_W-1:0] fifo_data;
  logic hs_busy;
  logic pop;
  logic [TSIO_DATA_W-1:0] hold_r;
  logic req_r;
  logic ack_m_r, ack_s_r, ack_d_r;
  logic rxt_m_r, rxt_s_r, rxt_d_r;
  logic [TSIO_CFG_W-1:0] cfg_r;
  logic tx_irq_r, rx_irq_r, rx_err_r;
  logic [TSIO_DATA_W-1:0] rx_data_r;

  // Link domain state, declared here for the crossings
  logic lrst_m_r, lrst_n_r;
  logic [TSIO_CFG_W-1:0] cfg_m_r, cfg_s_r;
  logic req_m_r, req_s_r;
  logic ack_r;
  logic rx_tgl_r;
  logic rx_bad_r;
  logic [TSIO_DATA_W-1:0] rx_word_r;

  // Buffer absorbs bursts; its ready is the write port's back-pressure
  tsio_fifo #(.WIDTH(TSIO_DATA_W), .DEPTH(TSIO_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(transmit_buffer_wr),
    .in_ready(transmit_buffer_rdy),
    .in_data(transmit_buffer_data),
    .out_valid(fifo_valid),
    .out_ready(!hs_busy),
    .out_data(fifo_data)
  );

  // One word in flight; nothing leaves the buffer while the function is off, so all sixteen words wait
  assign hs_busy = (req_r != ack_s_r) || !cfg_r[TSIO_CFG_W-1];
  assign pop = fifo_valid && !hs_busy;

  // group gating
  // Configuration registered once so the crossing sees flop outputs only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= {serial_en && (group_id < TSIO_SER_GROUPS), mode_async, half_bit};
    end
  end

  // Word handed to link side; held stable until the frame is acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= TSIO_DATA_RST;
      req_r <= 1'b0;
    end else if (pop) begin
      hold_r <= fifo_data;
      req_r <= ~req_r;
    end
  end

  // Acknowledge and receive toggles synchronised back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      ack_d_r <= 1'b0;
      rxt_m_r <= 1'b0;
      rxt_s_r <= 1'b0;
      rxt_d_r <= 1'b0;
    end else begin
      ack_m_r <= ack_r;
      ack_s_r <= ack_m_r;
      ack_d_r <= ack_s_r;
      rxt_m_r <= rx_tgl_r;
      rxt_s_r <= rxt_m_r;
      rxt_d_r <= rxt_s_r;
    end
  end

  // transmit request
  // Acknowledge toggles only after the last bit period closed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= (ack_s_r != ack_d_r);
    end
  end

  // receive request
  // Received word is stable for a whole frame after its toggle, safe to take
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq_r <= 1'b0;
      rx_err_r <= 1'b0;
      rx_data_r <= TSIO_DATA_RST;
    end else begin
      rx_irq_r <= (rxt_s_r != rxt_d_r) && !rx_bad_r;
      rx_err_r <= (rxt_s_r != rxt_d_r) && rx_bad_r;
      if ((rxt_s_r != rxt_d_r) && !rx_bad_r) rx_data_r <= rx_word_r;
    end
  end

  assign tx_irq = tx_irq_r;
  assign rx_irq = rx_irq_r;
  assign rx_err = rx_err_r;
  assign rx_data = rx_data_r;

  // ---------------- Link clock domain ----------------
  logic en_l, async_l;
  logic [TSIO_TMR_W-1:0] half_l;
  logic rxp_m_r, rxp_s_r, rxp_d_r;
  tsio_tx_st_t tx_st_r;
  tsio_rx_st_t rx_st_r;
  logic [TSIO_TMR_W-1:0] tx_tmr_r, rx_tmr_r;
  logic tx_wave_r, rx_wave_r;
  logic [TSIO_FRAME_W-1:0] tx_sh_r;
  logic [3:0] tx_idx_r, rx_idx_r;
  logic [TSIO_DATA_W-1:0] rx_sh_r;
  logic tx_pin_r, clk_pin_r;
  logic tx_load, tx_match, tx_bound, tx_finish;
  logic rx_fall, rx_start, rx_match, rx_sample;

  // Reset asserts at once, releases on the link clock
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_m_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_m_r <= 1'b1;
      lrst_n_r <= lrst_m_r;
    end
  end

  // Configuration is quasi static; change it only while the link is idle
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      cfg_m_r <= '0;
      cfg_s_r <= '0;
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      rxp_m_r <= TSIO_LINE_IDLE;
      rxp_s_r <= TSIO_LINE_IDLE;
      rxp_d_r <= TSIO_LINE_IDLE;
    end else begin
      cfg_m_r <= cfg_r;
      cfg_s_r <= cfg_m_r;
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      rxp_m_r <= serial_rx_pin;
      rxp_s_r <= rxp_m_r;
      rxp_d_r <= rxp_s_r;
    end
  end

  assign en_l = cfg_s_r[TSIO_CFG_W-1];
  assign async_l = cfg_s_r[TSIO_CFG_W-2];
  assign half_l = cfg_s_r[TSIO_TMR_W-1:0];

  // toggle on match
  // Base timer resets on match so the channel paces half bit periods
  assign tx_match = (tx_st_r == TSIO_TX_SHIFT) && (tx_tmr_r == half_l);
  assign tx_bound = tx_match && !tx_wave_r;
  assign tx_finish = tx_bound && (tx_idx_r == (async_l ? TSIO_ASYNC_LAST : TSIO_SYNC_LAST));
  assign tx_load = (tx_st_r == TSIO_TX_IDLE) && en_l && (req_s_r != ack_r);

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      tx_tmr_r <= TSIO_TMR_RST;
      tx_wave_r <= TSIO_WAVE_RST;
    end else if (tx_st_r != TSIO_TX_SHIFT || tx_match) begin
      tx_tmr_r <= TSIO_TMR_RST;
      tx_wave_r <= (tx_st_r == TSIO_TX_SHIFT) ? ~tx_wave_r : TSIO_WAVE_RST;
    end else begin
      tx_tmr_r <= tx_tmr_r + 16'h0001;
    end
  end

  // start low, stop high, LSB first
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      tx_st_r <= TSIO_TX_IDLE;
      tx_sh_r <= TSIO_SHIFT_RST;
      tx_idx_r <= TSIO_IDX_RST;
      tx_pin_r <= TSIO_LINE_IDLE;
      ack_r <= 1'b0;
    end else begin
      case (tx_st_r)
        TSIO_TX_IDLE: begin
          tx_pin_r <= TSIO_LINE_IDLE;
          if (tx_load) begin
            tx_sh_r <= async_l ? {1'b1, hold_r, 1'b0} : {2'b11, hold_r};
            tx_pin_r <= async_l ? 1'b0 : hold_r[0];
            tx_idx_r <= TSIO_IDX_RST;
            tx_st_r <= TSIO_TX_SHIFT;
          end
        end
        TSIO_TX_SHIFT: begin
          if (tx_finish) begin
            ack_r <= req_s_r;
            tx_pin_r <= TSIO_LINE_IDLE;
            tx_st_r <= TSIO_TX_IDLE;
          end else if (tx_bound) begin
            tx_sh_r <= {1'b1, tx_sh_r[TSIO_FRAME_W-1:1]};
            tx_pin_r <= tx_sh_r[1];
            tx_idx_r <= tx_idx_r + 4'h1;
          end
        end
        default: tx_st_r <= TSIO_TX_IDLE;
      endcase
    end
  end

  // Partner samples on the falling edge, mid-bit; clock rests high
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      clk_pin_r <= TSIO_LINE_IDLE;
    end else begin
      clk_pin_r <= (tx_st_r == TSIO_TX_SHIFT && !async_l) ? tx_wave_r : TSIO_LINE_IDLE;
    end
  end

  assign serial_tx_pin = tx_pin_r;
  assign serial_clk_pin = clk_pin_r;

  assign rx_fall = rxp_d_r && !rxp_s_r;
  assign rx_start = (rx_st_r == TSIO_RX_IDLE) && en_l && async_l && rx_fall;
  assign rx_match = (rx_st_r == TSIO_RX_RUN) && (rx_tmr_r == half_l);
  assign rx_sample = rx_match && rx_wave_r;

  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      rx_tmr_r <= TSIO_TMR_RST;
      rx_wave_r <= TSIO_WAVE_RST;
    end else if (rx_st_r != TSIO_RX_RUN || rx_match) begin
      rx_tmr_r <= TSIO_TMR_RST;
      rx_wave_r <= (rx_st_r == TSIO_RX_RUN) ? ~rx_wave_r : TSIO_WAVE_RST;
    end else begin
      rx_tmr_r <= rx_tmr_r + 16'h0001;
    end
  end

  // mid-bit sampling
  // First sample lands half a bit after the edge, then every full bit
  always_ff @(posedge link_clk or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      rx_st_r <= TSIO_RX_IDLE;
      rx_idx_r <= TSIO_IDX_RST;
      rx_sh_r <= TSIO_DATA_RST;
      rx_word_r <= TSIO_DATA_RST;
      rx_bad_r <= 1'b0;
      rx_tgl_r <= 1'b0;
    end else begin
      case (rx_st_r)
        TSIO_RX_IDLE: begin
          if (rx_start) begin
            rx_idx_r <= TSIO_IDX_RST;
            rx_st_r <= TSIO_RX_RUN;
          end
        end
        TSIO_RX_RUN: begin
          if (rx_sample) begin
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == TSIO_RX_START) begin
              // Glitch shorter than half a bit is not a start
              if (rxp_s_r) rx_st_r <= TSIO_RX_IDLE;
            end else if (rx_idx_r == TSIO_RX_STOP) begin
              rx_bad_r <= !rxp_s_r;
              if (rxp_s_r) rx_word_r <= rx_sh_r;
              rx_tgl_r <= ~rx_tgl_r;
              rx_st_r <= TSIO_RX_IDLE;
            end else begin
              rx_sh_r <= {rxp_s_r, rx_sh_r[TSIO_DATA_W-1:1]};
            end
          end
        end
        default: rx_st_r <= TSIO_RX_IDLE;
      endcase
    end
  end

  // ---------------- Assertions ----------------
  sequence s_load_async;
    tx_load && async_l;
  endsequence
  sequence s_frame_open;
    (tx_st_r == TSIO_TX_SHIFT) && !serial_tx_pin;
  endsequence

  group_gate_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (!en_l && tx_st_r == TSIO_TX_IDLE && rx_st_r == TSIO_RX_IDLE) |=>
      (tx_st_r == TSIO_TX_IDLE && rx_st_r == TSIO_RX_IDLE))
    else $error("serial activity while function disabled");

  wave_toggle_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    tx_match |=> (tx_wave_r != $past(tx_wave_r)) && (tx_tmr_r == TSIO_TMR_RST))
    else $error("compare output did not invert on match");

  sync_clock_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (tx_st_r == TSIO_TX_SHIFT && !async_l) |=> (serial_clk_pin == $past(tx_wave_r)))
    else $error("sync transfer clock not from compare output");

  write_shift_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (tx_load && !async_l) |=> (tx_st_r == TSIO_TX_SHIFT) && (serial_tx_pin == $past(hold_r[0])))
    else $error("buffer write did not start shifting");

  start_bit_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    s_load_async |=> s_frame_open)
    else $error("frame did not open with low start bit");

  stop_done_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (tx_finish && async_l) |-> serial_tx_pin ##1 (ack_r == $past(req_s_r)))
    else $error("frame ended without high stop bit");

  rx_launch_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    rx_start |=> (rx_st_r == TSIO_RX_RUN) && (rx_tmr_r == TSIO_TMR_RST) && rx_wave_r)
    else $error("start edge did not launch receive clock");

  rx_stop_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (rx_sample && rx_idx_r == TSIO_RX_STOP) |=>
      (rx_tgl_r != $past(rx_tgl_r)) && (rx_st_r == TSIO_RX_IDLE))
    else $error("stop bit did not raise receive event");

  idle_high_a: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
    (tx_st_r == TSIO_TX_IDLE && $past(tx_st_r) == TSIO_TX_IDLE) |-> serial_tx_pin)
    else $error("transmit line not high while idle");

  tx_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ack_s_r != ack_d_r) |=> tx_irq ##1 !tx_irq)
    else $error("transmit request not a single pulse after ack");
endmodule : tsio_top

// ===== tsio_peer.sv
// Serial partner model: decodes frames from the device and sends frames to it
`timescale 1ns/1ps
module tsio_peer (
  input wire logic link_clk,        // Bit timing clock
  input wire logic [15:0] half_bit, // Half bit length minus one
  input wire logic mode_async,      // 1 UART framing, 0 clocked
  input wire logic serial_tx_pin,   // Data from the device
  input wire logic serial_clk_pin,  // Transfer clock from the device
  output logic serial_rx_pin        // Data to the device
);
  logic [7:0] got_q[$];
  logic [7:0] sh_r;
  int got_n = 0;
  int fr_err = 0;
  int clk_bad = 0;
  int sb = 0;
  int lo = 0;

  // Line idles high until a frame is sent
  initial serial_rx_pin = 1'b1;

  // UART decode: mid-bit samples, LSB first, stop must be high
  always @(negedge serial_tx_pin) begin
    if (mode_async) begin
      repeat (half_bit + 1) @(posedge link_clk);
      #1;
      if (serial_tx_pin !== 1'b0) fr_err++;
      for (int i = 0; i < 9; i++) begin
        repeat (2 * (half_bit + 1)) @(posedge link_clk);
        #1;
        if (i < 8) sh_r = {serial_tx_pin, sh_r[7:1]};
      end
      if (serial_tx_pin !== 1'b1) fr_err++;
      got_q.push_back(sh_r);
      got_n++;
    end
  end

  // clocked decode on the falling transfer clock, LSB first
  always @(negedge serial_clk_pin) begin
    if (!mode_async) begin
      sh_r = {serial_tx_pin, sh_r[7:1]};
      sb++;
      if (sb == 8) begin
        got_q.push_back(sh_r);
        got_n++;
        sb = 0;
      end
    end
  end

  // low phase lasts one compare period; sampled mid-cycle to dodge the launch edge
  always @(negedge link_clk) begin
    if (serial_clk_pin === 1'b0) lo++;
    else begin
      if (lo != 0 && lo != half_bit + 1) clk_bad++;
      lo = 0;
    end
  end

  // Low pulse shorter than half a bit; the device must not take it as a start
  task automatic glitch();
    @(posedge link_clk);
    #1;
    serial_rx_pin = 1'b0;
    @(posedge link_clk);
    #1;
    serial_rx_pin = 1'b1;
  endtask : glitch

  // frame to the device: start low, data LSB first, stop level, one idle bit
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge link_clk);
      #1;
      serial_rx_pin = i < 10 ? f[i] : 1'b1;
      repeat (2 * (half_bit + 1) - 1) @(posedge link_clk);
    end
  endtask : send
endmodule : tsio_peer

// ===== tb.sv
// Self-checking bench for the timer based serial block
`timescale 1ns/1ps
module tb;
  import tsio_pkg::*;
  logic clk, rst_n, link_clk, serial_en, mode_async, transmit_buffer_wr, transmit_buffer_rdy;
  logic [TSIO_GRP_W-1:0] group_id;
  logic [TSIO_TMR_W-1:0] half_bit;
  logic [TSIO_DATA_W-1:0] transmit_buffer_data, rx_data, d, old;
  logic tx_irq, rx_irq, rx_err, serial_tx_pin, serial_clk_pin, serial_rx_pin, last_err;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int tx_irqs = 0;
  int rx_evs = 0;
  int sent = 0;
  int k, g;

  tsio_top uut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .serial_en(serial_en), .group_id(group_id),
    .mode_async(mode_async), .half_bit(half_bit), .transmit_buffer_wr(transmit_buffer_wr),
    .transmit_buffer_rdy(transmit_buffer_rdy), .transmit_buffer_data(transmit_buffer_data), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .rx_err(rx_err), .rx_data(rx_data), .serial_tx_pin(serial_tx_pin),
    .serial_clk_pin(serial_clk_pin), .serial_rx_pin(serial_rx_pin));
  tsio_peer peer (.link_clk(link_clk), .half_bit(half_bit), .mode_async(mode_async),
    .serial_tx_pin(serial_tx_pin), .serial_clk_pin(serial_clk_pin), .serial_rx_pin(serial_rx_pin));

  // System clock, and a link clock unrelated in phase
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (tx_irq === 1'b1) begin
      tx_irqs++;
      chk("frames_at_tx_irq", tx_irqs, peer.got_n);
    end
    if (rx_irq === 1'b1 || rx_err === 1'b1) begin
      rx_evs++;
      last_err = rx_err;
    end
  end

  function automatic int cnt(input int w);
    return w == 0 ? peer.got_n : (w == 1 ? tx_irqs : rx_evs);
  endfunction : cnt

  // Bounded wait on a counter; running out ends the run
  task automatic wait_for(input int w, input int n);
    int t;
    t = 0;
    while (cnt(w) < n && t < 40000) begin
      @(posedge clk);
      t++;
    end
    if (cnt(w) < n) begin
      chk("wait_counter", n, cnt(w));
      summarize();
    end
    #1;
  endtask : wait_for

  function automatic logic [7:0] pick(input int j);
    return j == 0 ? 8'h00 : (j == 1 ? 8'hff : 8'($urandom));
  endfunction : pick

  // Offer n words; a word counts only if the buffer had room at that edge
  task automatic burst(input int n);
    for (int j = 0; j < n; j++) begin
      d = pick(j);
      if (transmit_buffer_rdy === 1'b1) exp_q.push_back(d);
      transmit_buffer_data = d;
      transmit_buffer_wr = 1'b1;
      @(posedge clk);
      #1;
    end
    transmit_buffer_wr = 1'b0;
  endtask : burst

  task automatic drain();
    wait_for(0, sent + exp_q.size());
    wait_for(1, sent + exp_q.size());
    while (exp_q.size() > 0) begin
      sent++;
      chk("tx_word", exp_q.pop_front(), peer.got_q.pop_front());
    end
  endtask : drain

  // Settings change only while idle; the link side needs a few link cycles to see them
  task automatic cfg(input logic en, input logic [1:0] grp, input logic as, input logic [15:0] h);
    serial_en = en;
    group_id = grp;
    mode_async = as;
    half_bit = h;
    repeat (20) @(posedge clk);
    #1;
  endtask : cfg

  initial begin
    rst_n = 1'b0;
    serial_en = 1'b0;
    group_id = 2'h0;
    mode_async = 1'b1;
    half_bit = 16'h0001;
    transmit_buffer_wr = 1'b0;
    transmit_buffer_data = 8'h00;
    last_err = 1'b0;
    void'($urandom(50));
    // Held long enough for three link edges as well
    repeat (12) @(posedge clk);
    chk("rdy_rst", 1, transmit_buffer_rdy);
    chk("tx_pin_rst", 1, serial_tx_pin);
    chk("clk_pin_rst", 1, serial_clk_pin);
    chk("rx_data_rst", 0, rx_data);
    #1;
    rst_n = 1'b1;
    // Fill while disabled: sixteen taken, the rest refused
    burst(20);
    chk("fill_count", 16, exp_q.size());
    chk("full_rdy", 0, transmit_buffer_rdy);
    // Groups 2 and 3 carry no serial function
    for (g = 2; g < 4; g++) begin
      cfg(1'b1, 2'(g), 1'b1, 16'h0001);
      repeat (300) @(posedge clk);
      chk("gated_frames", 0, peer.got_n);
      chk("gated_line", 1, serial_tx_pin);
    end
    cfg(1'b1, 2'h1, 1'b1, 16'h0001);
    drain();
    // UART then clocked passes over both groups and random bit lengths
    for (k = 0; k < 4; k++) begin
      cfg(1'b1, 2'(k & 1), k < 2, 16'(1 + $urandom % 4));
      burst(6);
      drain();
    end
    // Receive, one frame with a low stop bit
    cfg(1'b1, 2'h0, 1'b1, 16'h0002);
    g = rx_evs;
    peer.glitch();
    repeat (100) @(posedge clk);
    chk("rx_glitch", g, rx_evs);
    for (k = 0; k < 6; k++) begin
      d = pick(k);
      old = rx_data;
      g = rx_evs;
      peer.send(d, k != 3);
      wait_for(2, g + 1);
      chk("rx_err", k == 3, last_err);
      chk("rx_data", k == 3 ? old : d, rx_data);
    end
    // Clocked mode has no receive path
    cfg(1'b1, 2'h0, 1'b0, 16'h0002);
    g = rx_evs;
    peer.send(8'h5a, 1'b1);
    chk("rx_in_sync", g, rx_evs);
    chk("peer_frame_err", 0, peer.fr_err);
    chk("clk_low_len", 0, peer.clk_bad);
    chk("clk_idle", 1, serial_clk_pin);
    summarize();
  end
endmodule : tb
